/* timer16_capture_compare.sv */
// 16-bit up-counter with two capture/compare registers, prescaler, shared
// output pin, sticky event status and a level interrupt, behind an APB slave.
// Assumes capture pins are asynchronous to sys_clk and the APB master is on sys_clk.
//
// Function
// R1 - Free-run or edge-clear mode: compare A zero matches on step 0000 to 0001.
// R2 - Compare A zero: match A also after match, B edge capture, one-shot clear.
// R3 - Shared pin is either capture B input or timer output, never both.
// R4 - Register A capture: read collisions harmless; capture on stop is undefined.
// R5 - Software does not rewrite register A while the counter runs.
// R6 - Compare B zero matches as counter steps 0000 to 0001 after overflow.
// R7 - Compare B zero: match B also after match, A edge capture, one-shot clear.
// R8 - Register B capture: read collisions harmless; capture on stop is undefined.
// R9 - Register B accepts writes while the counter runs.
// R10 - Counter runs while mode bits are nonzero; both zero stops it.
// R11 - Software stops the timer before writing mode bits other than overflow.
// R12 - Capture input A valid edge is chosen in the prescaler register.
// R13 - Clearing modes or free-run with compare A at FFFF set overflow on wrap.
// R14 - Software never loads zero into register A in clear-on-match mode.
// R15 - Counter is 16 bits, counts once per count clock, wraps to zero.
`timescale 1ns/1ps
`default_nettype none

module timer16_capture_compare (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic capture_input_a,
  input wire logic capture_input_b,
  output logic timer_output_pin,
  output logic timer_output_pin_oe,
  output logic match_irq_a,
  output logic match_irq_b,
  output logic irq
);

  // Software-visible state
  logic [1:0] timer_mode_reg;
  logic overflow_flag;
  logic [5:0] prescaler_mode_reg;
  timer16_pkg::cap_ctl_t cap_ctl;
  logic [15:0] compare_capture_reg_a;
  logic [15:0] compare_capture_reg_b;
  logic [15:0] main_counter;
  logic [2:0] status;
  logic [2:0] irq_en;

  // Internal state
  logic [7:0] pre_div;
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic oneshot_pulse;
  logic running;
  logic tick;
  logic edge_a;
  logic edge_b;
  logic cap_event_a;
  logic cap_event_b;
  logic clear_now;
  timer16_pkg::timer_events_t ev;
  timer16_pkg::timer_mode_t mode;
  timer16_pkg::edge_sel_t edge_sel_a;
  timer16_pkg::edge_sel_t edge_sel_b;
  logic wr_en;
  logic rd_setup;
  logic [31:0] next_prdata;
  logic next_slverr;
  logic [7:0] div_mask;
  logic [2:0] sync_ok;

  // Decoded views of the control registers
  assign mode = timer16_pkg::timer_mode_t'(timer_mode_reg);
  assign edge_sel_a = timer16_pkg::edge_sel_t'(
    prescaler_mode_reg[timer16_pkg::PRE_EDGE_A_LSB +: 2]);
  assign edge_sel_b = timer16_pkg::edge_sel_t'(
    prescaler_mode_reg[timer16_pkg::PRE_EDGE_B_LSB +: 2]);
  assign running = (mode != timer16_pkg::MODE_STOP); // see R10
  assign wr_en = psel & penable & pwrite;
  assign rd_setup = psel & ~penable;

  // Two-flop synchronisers plus a third stage for edge detection
  // Stage 0 may go metastable; only stages 1 and 2 feed any logic
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
    end else begin
      sync_a <= {sync_a[1:0], capture_input_a};
      sync_b <= {sync_b[1:0], capture_input_b};
    end
  end

  // Marks the stages that hold a sampled pin level since reset; the
  // reset zeros would otherwise look like an edge against a high pin
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync_ok <= 3'h0;
    end else begin
      sync_ok <= {sync_ok[1:0], 1'b1};
    end
  end

  // Valid-edge detection on synchronised inputs
  // Edge select 11 yields no edge at all
  always_comb begin
    case (edge_sel_a) // see R12
      timer16_pkg::EDGE_FALL: edge_a = sync_a[2] & ~sync_a[1];
      timer16_pkg::EDGE_RISE: edge_a = ~sync_a[2] & sync_a[1];
      timer16_pkg::EDGE_BOTH: edge_a = sync_a[2] ^ sync_a[1];
      default: edge_a = 1'b0;
    endcase
    case (edge_sel_b)
      timer16_pkg::EDGE_FALL: edge_b = sync_b[2] & ~sync_b[1];
      timer16_pkg::EDGE_RISE: edge_b = ~sync_b[2] & sync_b[1];
      timer16_pkg::EDGE_BOTH: edge_b = sync_b[2] ^ sync_b[1];
      default: edge_b = 1'b0;
    endcase
    // Pin in output use never yields a capture B edge
    if (cap_ctl.out_en) begin
      edge_b = 1'b0; // see R3
    end
    // No edge until stage 2 holds a real pin level
    if (!sync_ok[2]) begin
      edge_a = 1'b0;
      edge_b = 1'b0;
    end
  end

  // Capture A is triggered by input B edges, capture B by input A edges
  // Nothing is captured while stopped, so a stop wins over a capture
  assign cap_event_a = cap_ctl.cap_a & edge_b & running;
  assign cap_event_b = cap_ctl.cap_b & edge_a & running;

  // Prescaler: count clock is sys_clk divided by 1, 2, 4 or 8
  always_comb begin
    case (prescaler_mode_reg[timer16_pkg::PRE_CLK_LSB +: 2])
      2'h0: div_mask = 8'h00;
      2'h1: div_mask = 8'h01;
      2'h2: div_mask = 8'h03;
      default: div_mask = 8'h07;
    endcase
  end
  // Divider is held at zero while stopped, so every start has the same phase
  assign tick = running & ((pre_div & div_mask) == div_mask);

  always_ff @(posedge sys_clk) begin
    if (rst || !running) begin
      pre_div <= timer16_pkg::PRE_DIV_RESET;
    end else begin
      pre_div <= pre_div + 8'h01;
    end
  end

  // Count-step events; compare of zero fires on the step 0000 to 0001
  // A register in capture use never matches; overflow needs free-run or A at maximum
  always_comb begin
    ev.match_a = tick & (main_counter == compare_capture_reg_a) & ~cap_ctl.cap_a; // see R1
    ev.match_b = tick & (main_counter == compare_capture_reg_b) & ~cap_ctl.cap_b; // see R6
    ev.overflow = tick & (main_counter == timer16_pkg::COUNT_MAX) &
      ((mode == timer16_pkg::MODE_FREE) ||
       (compare_capture_reg_a == timer16_pkg::COUNT_MAX)); // see R13
  end

  // Clear-and-start sources
  // Clear on match with compare A at zero would pin the counter at zero
  always_comb begin
    clear_now = 1'b0;
    case (mode)
      timer16_pkg::MODE_CLEAR_EDGE: clear_now = edge_a;
      timer16_pkg::MODE_CLEAR_MATCH: clear_now = ev.match_a;
      default: clear_now = 1'b0;
    endcase
    if (oneshot_pulse && cap_ctl.oneshot_en && running) begin
      clear_now = 1'b1; // see R2 see R7
    end
  end

  // Main counter: 16-bit up-count, wraps, stopped and zeroed in stop mode
  always_ff @(posedge sys_clk) begin
    if (rst || !running) begin
      main_counter <= timer16_pkg::COUNT_RESET; // see R10
    end else if (clear_now) begin
      main_counter <= timer16_pkg::COUNT_RESET;
    end else if (tick) begin
      main_counter <= main_counter + 16'h0001; // see R15
    end
  end

  // Register A: software write or capture; capture takes the counter value
  // No write lock while running: software keeps the counter stopped first
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      compare_capture_reg_a <= timer16_pkg::CMP_RESET;
    end else if (cap_event_a) begin
      compare_capture_reg_a <= main_counter; // see R4
    end else if (wr_en && paddr == timer16_pkg::OFF_REG_A) begin
      compare_capture_reg_a <= pwdata[15:0];
    end
  end

  // Register B: writes accepted in any cycle without a capture, including while running
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      compare_capture_reg_b <= timer16_pkg::CMP_RESET;
    end else if (cap_event_b) begin
      compare_capture_reg_b <= main_counter; // see R8
    end else if (wr_en && paddr == timer16_pkg::OFF_REG_B) begin
      compare_capture_reg_b <= pwdata[15:0]; // see R9
    end
  end

  // Mode, prescaler, capture control and interrupt enable registers
  // Writes land whether running or not; software stops the timer first
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      timer_mode_reg <= timer16_pkg::MODE_STOP;
      prescaler_mode_reg <= timer16_pkg::PRE_RESET;
      cap_ctl <= timer16_pkg::cap_ctl_t'(4'h0);
      irq_en <= timer16_pkg::IRQ_EN_RESET;
    end else if (wr_en) begin
      case (paddr)
        timer16_pkg::OFF_MODE: timer_mode_reg <= {
          pwdata[timer16_pkg::MODE_SEL_HIGH_BIT], pwdata[timer16_pkg::MODE_SEL_LOW_BIT]};
        timer16_pkg::OFF_PRESCALE: prescaler_mode_reg <= pwdata[5:0];
        timer16_pkg::OFF_CAPCTL: cap_ctl <= timer16_pkg::cap_ctl_t'(pwdata[3:0]);
        timer16_pkg::OFF_IRQ_EN: irq_en <= pwdata[2:0];
        default: ;
      endcase
    end
  end

  // One-shot trigger: write-one pulse, reads back as zero
  // It clears the counter only with one-shot use enabled and the counter running
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      oneshot_pulse <= 1'b0;
    end else begin
      oneshot_pulse <= wr_en && (paddr == timer16_pkg::OFF_CAPCTL) &&
        pwdata[timer16_pkg::ONESHOT_TRIG_BIT];
    end
  end

  // Sticky status: set wins over a clear in the same cycle
  // Writing zero to the mode overflow bit clears the overflow status too
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      status <= 3'h0;
    end else begin
      if (wr_en && paddr == timer16_pkg::OFF_CLEAR) begin
        status <= (status & ~pwdata[2:0]) | ev;
      end else if (wr_en && paddr == timer16_pkg::OFF_MODE &&
          !pwdata[timer16_pkg::MODE_OVF_BIT]) begin
        status <= (status & ~(3'h1 << timer16_pkg::ST_OVF)) | ev;
      end else begin
        status <= status | ev;
      end
      // Captures also raise their register's match status
      if (cap_event_a) begin
        status[timer16_pkg::ST_MATCH_A] <= 1'b1; // see R2
      end
      if (cap_event_b) begin
        status[timer16_pkg::ST_MATCH_B] <= 1'b1; // see R7
      end
    end
  end
  assign overflow_flag = status[timer16_pkg::ST_OVF];

  // Per-register match pulses and the level interrupt
  // The interrupt level lags the status by one clock
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      match_irq_a <= 1'b0;
      match_irq_b <= 1'b0;
      irq <= 1'b0;
    end else begin
      match_irq_a <= ev.match_a | cap_event_a; // see R2
      match_irq_b <= ev.match_b | cap_event_b; // see R7
      irq <= |(status & irq_en);
    end
  end

  // Timer output toggles on match A; drives the shared pin only when enabled
  // Held low while stopped or while the shared pin serves as capture input
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      timer_output_pin <= 1'b0;
      timer_output_pin_oe <= 1'b0;
    end else begin
      timer_output_pin_oe <= cap_ctl.out_en; // see R3
      if (!cap_ctl.out_en || !running) begin
        timer_output_pin <= 1'b0;
      end else if (ev.match_a) begin
        timer_output_pin <= ~timer_output_pin;
      end
    end
  end

  // APB read mux, evaluated in the setup cycle
  // Unmapped offsets answer with an error and zero data
  always_comb begin
    next_prdata = 32'h0000_0000;
    next_slverr = 1'b0;
    case (paddr)
      timer16_pkg::OFF_MODE: begin
        next_prdata[timer16_pkg::MODE_OVF_BIT] = overflow_flag;
        next_prdata[timer16_pkg::MODE_SEL_LOW_BIT] = timer_mode_reg[0];
        next_prdata[timer16_pkg::MODE_SEL_HIGH_BIT] = timer_mode_reg[1];
      end
      timer16_pkg::OFF_PRESCALE: next_prdata[5:0] = prescaler_mode_reg;
      timer16_pkg::OFF_CAPCTL: next_prdata[3:0] = cap_ctl;
      timer16_pkg::OFF_REG_A: next_prdata[15:0] = compare_capture_reg_a;
      timer16_pkg::OFF_REG_B: next_prdata[15:0] = compare_capture_reg_b;
      timer16_pkg::OFF_COUNT: next_prdata[15:0] = main_counter;
      timer16_pkg::OFF_STATUS: next_prdata[2:0] = status;
      timer16_pkg::OFF_CLEAR: next_prdata = 32'h0000_0000;
      timer16_pkg::OFF_IRQ_EN: next_prdata[2:0] = irq_en;
      default: next_slverr = 1'b1;
    endcase
  end

  // APB response: one wait-free access phase after setup
  // Read data is latched in setup and stands through the access phase
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (rd_setup) begin
        prdata <= pwrite ? 32'h0000_0000 : next_prdata;
        pslverr <= next_slverr;
      end
    end
  end

endmodule : timer16_capture_compare

`default_nettype wire

/* timer16_pkg.sv */
// Package for the 16-bit capture/compare timer: register map, field positions,
// reset values, mode encodings and the packed carriers used by the timer module.
// Assumes a 32-bit APB slave with byte addresses and one register per aligned word.
package timer16_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_PRESCALE = 8'h04;
  localparam logic [7:0] OFF_CAPCTL = 8'h08;
  localparam logic [7:0] OFF_REG_A = 8'h0c;
  localparam logic [7:0] OFF_REG_B = 8'h10;
  localparam logic [7:0] OFF_COUNT = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_CLEAR = 8'h1c;
  localparam logic [7:0] OFF_IRQ_EN = 8'h20;

  // Mode register fields
  localparam int MODE_OVF_BIT = 0;
  localparam int MODE_SEL_LOW_BIT = 2;
  localparam int MODE_SEL_HIGH_BIT = 3;
  // Prescaler register fields
  localparam int PRE_CLK_LSB = 0;
  localparam int PRE_EDGE_A_LSB = 2;
  localparam int PRE_EDGE_B_LSB = 4;
  // Capture control fields
  localparam int CAP_A_BIT = 0;
  localparam int CAP_B_BIT = 1;
  localparam int OUT_EN_BIT = 2;
  localparam int ONESHOT_EN_BIT = 3;
  localparam int ONESHOT_TRIG_BIT = 4;
  // Status / clear / enable bit positions
  localparam int ST_MATCH_A = 0;
  localparam int ST_MATCH_B = 1;
  localparam int ST_OVF = 2;

  // Reset values and the counter maximum
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [15:0] CMP_RESET = 16'h0000;
  localparam logic [5:0] PRE_RESET = 6'h00;
  localparam logic [4:0] CAPCTL_RESET = 5'h00;
  localparam logic [2:0] IRQ_EN_RESET = 3'h0;
  localparam logic [7:0] PRE_DIV_RESET = 8'h00;

  // Counter modes selected by the two mode-select bits
  typedef enum logic [1:0] {
    MODE_STOP = 2'b00,
    MODE_FREE = 2'b01,
    MODE_CLEAR_EDGE = 2'b10,
    MODE_CLEAR_MATCH = 2'b11
  } timer_mode_t;

  // Valid-edge selection for a capture input
  typedef enum logic [1:0] {
    EDGE_FALL = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_BOTH = 2'b10,
    EDGE_NONE = 2'b11
  } edge_sel_t;

  // Timer events of one count step
  typedef struct packed {
    logic overflow;
    logic match_b;
    logic match_a;
  } timer_events_t;

  // Capture/compare control fields
  typedef struct packed {
    logic oneshot_en;
    logic out_en;
    logic cap_b;
    logic cap_a;
  } cap_ctl_t;

endpackage : timer16_pkg

/* timer16_capture_compare_sva.sv */
// Checker for the capture/compare timer: APB answer timing and event pulses.
// Assumes it is bound to the top module and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module timer16_capture_compare_sva (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic timer_output_pin_oe,
  input wire logic match_irq_a,
  input wire logic match_irq_b,
  input wire logic irq
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // Reset quiets the bus answer and every event output
  a_ready_reset: assert property (disable iff (1'b0) rst |=> !pready)
    else $error("pready high after reset edge");
  a_reset_quiet: assert property (disable iff (1'b0)
    rst |=> !irq && !match_irq_a && !match_irq_b && !timer_output_pin_oe)
    else $error("event output high after reset edge");
  // Zero wait states once out of reset
  a_ready_steady: assert property (!$past(rst) |-> pready)
    else $error("pready low outside reset");
  // Unmapped places answer with an error and zero data
  a_unmapped_err: assert property (psel && !penable && paddr > 8'h20
    |=> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
  a_mapped_ok: assert property (psel && !penable && paddr <= 8'h20
    && paddr[1:0] == 2'b00 |=> !pslverr) else $error("mapped access refused");
  // Read answer stands until the next setup cycle
  a_rdata_hold: assert property (psel && !penable ##1 psel && penable
    |=> $stable(prdata) && $stable(pslverr)) else $error("read answer moved");
  // Match outputs are single-cycle pulses
  a_pulse_a_one: assert property (match_irq_a |=> !match_irq_a)
    else $error("match pulse a too long");
  a_pulse_b_one: assert property (match_irq_b |=> !match_irq_b)
    else $error("match pulse b too long");
endmodule : timer16_capture_compare_sva
`default_nettype wire

/* timer16_pins_model.sv */
// Model of the pins outside the timer: two trigger sources and the shared pin.
// Assumes the bench calls pulse and reads toggles by hierarchy.
`timescale 1ns/1ps
`default_nettype none
module timer16_pins_model (
  input wire logic sys_clk,
  input wire logic timer_output_pin,
  input wire logic timer_output_pin_oe,
  output logic capture_input_a,
  output logic capture_input_b
);
  logic drv_a = 1'b1;
  logic drv_b = 1'b1;
  logic out_q = 1'b0;
  int toggles = 0;
  // Shared pin carries the timer output while driven, else trigger b
  assign capture_input_a = drv_a;
  assign capture_input_b = timer_output_pin_oe ? timer_output_pin : drv_b;
  // Count output edges while the timer owns the pin
  always @(posedge sys_clk) begin
    if (timer_output_pin_oe && timer_output_pin !== out_q) toggles <= toggles + 1;
    out_q <= timer_output_pin;
  end
  // Low pulse wider than two count clocks plus the synchroniser
  task automatic pulse(input logic sel, input int width);
    @(posedge sys_clk);
    if (sel) drv_b <= 1'b0;
    else drv_a <= 1'b0;
    repeat (width) @(posedge sys_clk);
    if (sel) drv_b <= 1'b1;
    else drv_a <= 1'b1;
    repeat (width) @(posedge sys_clk);
  endtask : pulse
endmodule : timer16_pins_model
`default_nettype wire

/* timer16_capture_compare_tb_top.sv */
// Testbench for the capture/compare timer: APB tasks and directed tests.
// Assumes the pin model on the far side and the checker bound below.
`timescale 1ns/1ps
`default_nettype none
module timer16_capture_compare_tb_top;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, capture_input_a, capture_input_b;
  logic timer_output_pin, timer_output_pin_oe, match_irq_a, match_irq_b, irq;
  int err_total = 0;
  int n_compared = 0;
  logic [31:0] q;
  always #12.5 sys_clk = ~sys_clk;
  timer16_capture_compare timer16_capture_compare_i (.sys_clk, .rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .capture_input_a,
    .capture_input_b, .timer_output_pin, .timer_output_pin_oe, .match_irq_a,
    .match_irq_b, .irq);
  timer16_pins_model pins_i (.sys_clk, .timer_output_pin, .timer_output_pin_oe,
    .capture_input_a, .capture_input_b);
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer: setup, then access held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) begin
      err_total++;
      give_verdict();
    end
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rd
  // Main sequence
  initial begin
    int n;
    logic [31:0] c0;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 10; i++) if (i != 7) rd(8'(4 * i), 32'h0);
    $display("test reset done");
    wr(timer16_pkg::OFF_MODE, 32'h4);
    apb(1'b0, timer16_pkg::OFF_COUNT, 32'h0);
    c0 = q;
    chk(c0, 32'h1);
    rd(timer16_pkg::OFF_COUNT, c0 + 32'h3);
    wr(timer16_pkg::OFF_REG_B, 32'h1234);
    rd(timer16_pkg::OFF_REG_B, 32'h1234);
    wr(timer16_pkg::OFF_MODE, 32'h0);
    rd(timer16_pkg::OFF_COUNT, 32'h0);
    $display("test count done");
    wr(timer16_pkg::OFF_REG_A, 32'h3);
    wr(timer16_pkg::OFF_CAPCTL, 32'h4);
    wr(timer16_pkg::OFF_CLEAR, 32'h7);
    wr(timer16_pkg::OFF_MODE, 32'hc);
    repeat (40) @(posedge sys_clk);
    apb(1'b0, timer16_pkg::OFF_COUNT, 32'h0);
    chk(32'(q > 3), 32'h0);
    chk(32'(pins_i.toggles > 5), 32'h1);
    rd(timer16_pkg::OFF_STATUS, 32'h1);
    $display("test match done");
    wr(timer16_pkg::OFF_MODE, 32'h0);
    wr(timer16_pkg::OFF_CLEAR, 32'h7);
    wr(timer16_pkg::OFF_PRESCALE, 32'h4);
    wr(timer16_pkg::OFF_CAPCTL, 32'h7);
    wr(timer16_pkg::OFF_MODE, 32'h4);
    pins_i.pulse(1'b1, 8);
    pins_i.pulse(1'b0, 8);
    rd(timer16_pkg::OFF_STATUS, 32'h2);
    wr(timer16_pkg::OFF_MODE, 32'h0);
    wr(timer16_pkg::OFF_CAPCTL, 32'h3);
    wr(timer16_pkg::OFF_CLEAR, 32'h7);
    wr(timer16_pkg::OFF_MODE, 32'h4);
    pins_i.pulse(1'b1, 8);
    rd(timer16_pkg::OFF_STATUS, 32'h1);
    apb(1'b0, timer16_pkg::OFF_REG_A, 32'h0);
    chk(32'(q != 0), 32'h1);
    $display("test capture done");
    wr(timer16_pkg::OFF_MODE, 32'h0);
    wr(timer16_pkg::OFF_REG_A, 32'h0);
    wr(timer16_pkg::OFF_REG_B, 32'h0);
    wr(timer16_pkg::OFF_CAPCTL, 32'h8);
    wr(timer16_pkg::OFF_MODE, 32'h4);
    wr(timer16_pkg::OFF_CLEAR, 32'h7);
    rd(timer16_pkg::OFF_STATUS, 32'h0);
    wr(timer16_pkg::OFF_CAPCTL, 32'h18);
    repeat (3) @(posedge sys_clk);
    chk(32'({match_irq_b, match_irq_a}), 32'h3);
    rd(timer16_pkg::OFF_STATUS, 32'h3);
    $display("test one-shot done");
    wr(timer16_pkg::OFF_CLEAR, 32'h7);
    wr(timer16_pkg::OFF_IRQ_EN, 32'h7);
    chk(32'(irq), 32'h0);
    n = 0;
    while (irq !== 1'b1 && n < 70000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n == 70000) begin
      err_total++;
      give_verdict();
    end
    repeat (4) @(posedge sys_clk);
    rd(timer16_pkg::OFF_STATUS, 32'h7);
    rd(timer16_pkg::OFF_MODE, 32'h5);
    wr(timer16_pkg::OFF_IRQ_EN, 32'h0);
    repeat (2) @(posedge sys_clk);
    chk(32'(irq), 32'h0);
    wr(timer16_pkg::OFF_IRQ_EN, 32'h7);
    repeat (2) @(posedge sys_clk);
    chk(32'(irq), 32'h1);
    wr(timer16_pkg::OFF_CLEAR, 32'h7);
    wr(timer16_pkg::OFF_MODE, 32'h4);
    repeat (2) @(posedge sys_clk);
    chk(32'(irq), 32'h0);
    rd(timer16_pkg::OFF_MODE, 32'h4);
    $display("test wrap done");
    give_verdict();
  end
endmodule : timer16_capture_compare_tb_top
bind timer16_capture_compare timer16_capture_compare_sva timer16_capture_compare_sva_i (
  .sys_clk, .rst, .psel, .penable, .paddr, .prdata, .pready, .pslverr,
  .timer_output_pin_oe, .match_irq_a, .match_irq_b, .irq);
`default_nettype wire
